// ===== timer_counter_modes.sv
// Purpose: sequencing of one counter channel in modes 2 to 5
// Assumes: counterClock and gateIn are pins, sampled by the 10 MHz clock;
//          countWrite pulses once per complete count (second byte if two)
// Notes:   counterClock must stay well below half the system clock rate
`timescale 1ns/1ps
`default_nettype none
module timer_counter_modes
    import timer_counter_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        counterClock,
    input  wire logic        gateIn,
    input  wire logic        controlWrite,
    input  wire logic [2:0]  modeSelect,
    input  wire logic        bcdSelect,
    input  wire logic        countWrite,
    input  wire logic [15:0] countData,
    output var  logic        timerOut,
    output var  logic [15:0] countValue
);

    logic [1:0]  rstSync_q;
    logic        rst_n;
    logic [2:0]  clkSync_q;
    logic [2:0]  gateSync_q;
    logic [3:0]  primed_q;
    logic        clkLvl_q;
    logic        gateLvl_q;
    logic        clkRise;
    logic        clkFall;
    logic        gateRise;
    logic        gateFall;
    logic        trigPend_q;
    logic        trigSeen_q;
    logic        gateEn_q;
    logic [2:0]  mode_q;
    logic        bcd_q;
    logic [15:0] hold_q;
    logic        pend_q;
    logic        started_q;
    logic        fresh_q;
    logic        fire_q;
    logic        out_q;
    logic [15:0] ce_q;
    logic [1:0]  sqStep;
    logic        sqOdd;

    // decimal digit borrow
    // subtract 1..3, binary or four-digit decimal
    function automatic logic [15:0] countDown(
        input logic [15:0] v,
        input logic [1:0]  s,
        input logic        dec
    );
        logic [15:0] r;
        logic [4:0]  t;
        logic [1:0]  b;
        r = v - {14'h0000, s};
        b = s;
        if (dec)
        begin
            for (int i = 0; i < 4; i++)
            begin
                t = {1'b0, v[4*i +: 4]} - {3'h0, b};
                if (t[4])
                begin
                    r[4*i +: 4] = t[3:0] + DIGIT_RADIX;
                    b = STEP_ONE;
                end
                else
                begin
                    r[4*i +: 4] = t[3:0];
                    b = 2'h0;
                end
            end
        end
        return r;
    endfunction

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rstSync_q <= 2'h0;
        else
            rstSync_q <= {rstSync_q[0], 1'b1};
    end
    assign rst_n = rstSync_q[1];

    // pins pass three flops; a level counts once stages two and three agree
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            primed_q   <= 4'h0;
            clkSync_q  <= 3'h0;
            gateSync_q <= 3'h0;
            clkLvl_q   <= 1'b0;
            gateLvl_q  <= 1'b0;
        end
        else
        begin
            primed_q   <= {primed_q[2:0], 1'b1};
            clkSync_q  <= {clkSync_q[1:0], counterClock};
            gateSync_q <= {gateSync_q[1:0], gateIn};
            // copy levels until the chain holds real pin values, so a pin
            // idling high after reset gives no false edge
            if (!primed_q[3] || clkSync_q[1] == clkSync_q[2])
                clkLvl_q <= clkSync_q[2];
            if (!primed_q[3] || gateSync_q[1] == gateSync_q[2])
                gateLvl_q <= gateSync_q[2];
        end
    end

    assign clkRise  = primed_q[3] && (clkSync_q[1] == clkSync_q[2])
                      && clkSync_q[2] && !clkLvl_q;
    assign clkFall  = primed_q[3] && (clkSync_q[1] == clkSync_q[2])
                      && !clkSync_q[2] && clkLvl_q;
    assign gateRise = primed_q[3] && (gateSync_q[1] == gateSync_q[2])
                      && gateSync_q[2] && !gateLvl_q;
    assign gateFall = primed_q[3] && (gateSync_q[1] == gateSync_q[2])
                      && !gateSync_q[2] && gateLvl_q;

    // trigger capture, sampled and cleared at clock rise
    // gate level sampled at clock rise
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trigPend_q <= 1'b0;
            trigSeen_q <= 1'b0;
            gateEn_q   <= 1'b0;
        end
        else if (controlWrite)
        begin
            trigPend_q <= 1'b0;
            trigSeen_q <= 1'b0;
            gateEn_q   <= gateLvl_q;
        end
        else if (clkRise)
        begin
            trigSeen_q <= trigPend_q || gateRise;
            trigPend_q <= 1'b0;
            gateEn_q   <= gateLvl_q;
        end
        else
        begin
            if (gateRise)
                trigPend_q <= 1'b1;
            if (clkFall)
                trigSeen_q <= 1'b0;
        end
    end

    assign sqOdd  = hold_q[0];
    // odd counts step one (high) or three (low) right after a load
    assign sqStep = (fresh_q && sqOdd) ? (out_q ? STEP_ONE : STEP_THREE)
                                       : STEP_TWO;

    // count holding register; a write while a load happens stays pending
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_q <= COUNT_RESET;
            mode_q <= MODE_RESET;
            bcd_q  <= 1'b0;
        end
        else
        begin
            if (controlWrite)
            begin
                mode_q <= modeSelect;
                bcd_q  <= bcdSelect;
            end
            if (countWrite)
                hold_q <= countData;
        end
    end

    // counting element and output; loads and steps only on clock fall
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ce_q      <= COUNT_RESET;
            out_q     <= OUT_RESET;
            pend_q    <= 1'b0;
            started_q <= 1'b0;
            fresh_q   <= 1'b0;
            fire_q    <= 1'b0;
        end
        // immediate reset of control logic and output
        else if (controlWrite)
        begin
            out_q     <= (modeSelect != MODE_TERMINAL);
            pend_q    <= 1'b0;
            started_q <= 1'b0;
            fresh_q   <= 1'b0;
            fire_q    <= 1'b0;
        end
        else
        begin
            if (clkFall)
            begin
                unique case (mode_q)
                    MODE_RATE:
                    begin
                        if ((pend_q && !started_q) || trigSeen_q)
                        begin
                            ce_q      <= hold_q;
                            out_q     <= 1'b1;
                            pend_q    <= countWrite;
                            started_q <= 1'b1;
                        end
                        // low at one, reload on next pulse
                        else if (started_q && gateEn_q)
                        begin
                            if (ce_q == COUNT_ONE)
                            begin
                                ce_q   <= hold_q;
                                out_q  <= 1'b1;
                                pend_q <= countWrite;
                            end
                            else
                            begin
                                ce_q  <= countDown(ce_q, STEP_ONE, bcd_q);
                                out_q <= (countDown(ce_q, STEP_ONE, bcd_q)
                                          != COUNT_ONE);
                            end
                        end
                    end
                    MODE_SQUARE:
                    begin
                        if ((pend_q && !started_q) || trigSeen_q)
                        begin
                            ce_q      <= hold_q;
                            out_q     <= 1'b1;
                            pend_q    <= countWrite;
                            started_q <= 1'b1;
                            fresh_q   <= 1'b1;
                        end
                        // expiry toggles and reloads; zero is max
                        else if (started_q && gateEn_q)
                        begin
                            fresh_q <= 1'b0;
                            if (ce_q == {14'h0000, sqStep})
                            begin
                                ce_q    <= hold_q;
                                out_q   <= !out_q;
                                pend_q  <= countWrite;
                                fresh_q <= 1'b1;
                            end
                            else
                                ce_q <= countDown(ce_q, sqStep, bcd_q);
                        end
                    end
                    MODE_SW_STROBE:
                    begin
                        out_q <= 1'b1;
                        if (pend_q)
                        begin
                            ce_q   <= hold_q;
                            pend_q <= countWrite;
                            fire_q <= 1'b1;
                        end
                        else if (gateEn_q)
                        begin
                            // wraps past zero and keeps counting
                            ce_q <= countDown(ce_q, STEP_ONE, bcd_q);
                            if (fire_q && ce_q == COUNT_ONE)
                            begin
                                out_q  <= 1'b0;
                                fire_q <= 1'b0;
                            end
                        end
                    end
                    MODE_HW_STROBE:
                    begin
                        out_q <= 1'b1;
                        // load only on the pulse after a trigger
                        if (trigSeen_q && started_q)
                        begin
                            ce_q   <= hold_q;
                            fire_q <= 1'b1;
                        end
                        else
                        begin
                            ce_q <= countDown(ce_q, STEP_ONE, bcd_q);
                            if (fire_q && ce_q == COUNT_ONE)
                            begin
                                out_q  <= 1'b0;
                                fire_q <= 1'b0;
                            end
                        end
                    end
                    default:
                    begin
                        out_q <= out_q;
                    end
                endcase
            end
            // gate low forces output high without a pulse
            // placed after the step so it wins over a same-cycle expiry
            if (gateFall && (mode_q == MODE_RATE || mode_q == MODE_SQUARE))
                out_q <= 1'b1;
            // a complete write marks the count pending
            if (countWrite)
            begin
                pend_q <= 1'b1;
                if (mode_q == MODE_HW_STROBE)
                    started_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timerOut   <= OUT_RESET;
            countValue <= COUNT_RESET;
        end
        else
        begin
            timerOut   <= out_q;
            countValue <= ce_q;
        end
    end

    property p_ctrl_init;
        @(posedge clock) disable iff (!rst_n)
        controlWrite |=> (out_q == (mode_q != MODE_TERMINAL)) && !fire_q;
    endproperty
    a_ctrl_init: assert property (p_ctrl_init)
        else $error("control word did not set initial output");

    property p_gate_fall_high;
        @(posedge clock) disable iff (!rst_n)
        (gateFall && !controlWrite
         && (mode_q == MODE_RATE || mode_q == MODE_SQUARE)) |=> out_q;
    endproperty
    a_gate_fall_high: assert property (p_gate_fall_high)
        else $error("gate fall did not force output high");

    property p_rate_low_at_one;
        @(posedge clock) disable iff (!rst_n)
        (mode_q == MODE_RATE && $fell(out_q)) |-> ce_q == COUNT_ONE;
    endproperty
    a_rate_low_at_one: assert property (p_rate_low_at_one)
        else $error("rate output low with count not one");

    property p_strobe_at_zero;
        @(posedge clock) disable iff (!rst_n)
        ((mode_q == MODE_SW_STROBE || mode_q == MODE_HW_STROBE)
         && $fell(out_q)) |-> ce_q == COUNT_RESET;
    endproperty
    a_strobe_at_zero: assert property (p_strobe_at_zero)
        else $error("strobe low with count not zero");

    property p_square_toggle;
        @(posedge clock) disable iff (!rst_n)
        (mode_q == MODE_SQUARE && clkFall && started_q && gateEn_q
         && !trigSeen_q && !controlWrite && !gateFall
         && ce_q == {14'h0000, sqStep})
        |=> (out_q != $past(out_q)) && ce_q == $past(hold_q);
    endproperty
    a_square_toggle: assert property (p_square_toggle)
        else $error("square expiry did not toggle and reload");

    property p_fall_only;
        @(posedge clock) disable iff (!rst_n)
        (ce_q != $past(ce_q)) |-> $past(clkFall);
    endproperty
    a_fall_only: assert property (p_fall_only)
        else $error("count changed away from clock fall");

    property p_trig_clear;
        @(posedge clock) disable iff (!rst_n)
        (clkRise && !gateRise) |=> !trigPend_q;
    endproperty
    a_trig_clear: assert property (p_trig_clear)
        else $error("trigger capture not cleared after sampling");

    property p_wrap;
        @(posedge clock) disable iff (!rst_n)
        (mode_q == MODE_SW_STROBE && clkFall && !pend_q && gateEn_q
         && !controlWrite && ce_q == COUNT_RESET)
        |=> ce_q == (bcd_q ? WRAP_DECIMAL : WRAP_BINARY);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap from zero");

    property p_gate_pause;
        @(posedge clock) disable iff (!rst_n)
        (mode_q == MODE_SW_STROBE && clkFall && !pend_q && !gateEn_q
         && !controlWrite) |=> $stable(ce_q) && out_q;
    endproperty
    a_gate_pause: assert property (p_gate_pause)
        else $error("gate low did not pause counting");

    c_rate_pulse: cover property (@(posedge clock) disable iff (!rst_n)
        mode_q == MODE_RATE && $fell(out_q));
    c_square_toggle: cover property (@(posedge clock) disable iff (!rst_n)
        mode_q == MODE_SQUARE && $rose(out_q));
    c_sw_strobe: cover property (@(posedge clock) disable iff (!rst_n)
        mode_q == MODE_SW_STROBE && $fell(out_q));
    c_hw_retrigger: cover property (@(posedge clock) disable iff (!rst_n)
        mode_q == MODE_HW_STROBE && clkFall && trigSeen_q && fire_q);

endmodule // timer_counter_modes
`default_nettype wire

// ===== timer_counter_pkg.sv
// Purpose: shared constants for the interval timer counter channel
// Assumes: 16-bit counting element, modes coded 0..5 as in the control word
// Notes:   modes 0 and 1 are only given their initial output level here
`default_nettype none
package timer_counter_pkg;
    localparam int          COUNT_WIDTH     = 16;
    localparam logic [2:0]  MODE_TERMINAL   = 3'h0;
    localparam logic [2:0]  MODE_ONE_SHOT   = 3'h1;
    localparam logic [2:0]  MODE_RATE       = 3'h2;
    localparam logic [2:0]  MODE_SQUARE     = 3'h3;
    localparam logic [2:0]  MODE_SW_STROBE  = 3'h4;
    localparam logic [2:0]  MODE_HW_STROBE  = 3'h5;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [15:0] WRAP_BINARY     = 16'hFFFF;
    localparam logic [15:0] WRAP_DECIMAL    = 16'h9999;
    localparam logic [15:0] COUNT_ONE       = 16'h0001;
    localparam logic [1:0]  STEP_ONE        = 2'h1;
    localparam logic [1:0]  STEP_TWO        = 2'h2;
    localparam logic [1:0]  STEP_THREE      = 2'h3;
    localparam logic [2:0]  MODE_RESET      = 3'h0;
    localparam logic        OUT_RESET       = 1'b0;
    localparam logic [3:0]  DIGIT_RADIX     = 4'hA;
endpackage : timer_counter_pkg
`default_nettype wire

// ===== host_model.sv
// Purpose: host side writing control words and counts
// Assumes: one-cycle write strobes, changed just after clock rise
// Notes:   called hierarchically by the testbench
`timescale 1ns/1ps
`default_nettype none
module host_model
    import timer_counter_pkg::*;
(
    input  wire logic        clock,
    output var  logic        controlWrite,
    output var  logic [2:0]  modeSelect,
    output var  logic        bcdSelect,
    output var  logic        countWrite,
    output var  logic [15:0] countData
);
    initial
    begin
        controlWrite = 1'b0;
        modeSelect   = MODE_RESET;
        bcdSelect    = 1'b0;
        countWrite   = 1'b0;
        countData    = COUNT_RESET;
    end

    task automatic writeControl(input logic [2:0] mode, input logic bcd);
        controlWrite <= 1'b1;
        modeSelect   <= mode;
        bcdSelect    <= bcd;
        @(posedge clock);
        controlWrite <= 1'b0;
        @(posedge clock);
    endtask

    // legal counts only
    // callers never pass a count below the mode minimum
    task automatic writeCount(input logic [15:0] value);
        countWrite <= 1'b1;
        countData  <= value;
        @(posedge clock);
        countWrite <= 1'b0;
        @(posedge clock);
    endtask
endmodule // host_model
`default_nettype wire

// ===== tb_timer_counter_modes.sv
// Purpose: self-checking bench for the counter channel in modes 2 to 5
// Assumes: counter clock levels last 5 or more system clocks
// Notes:   pin filter latency absorbed by waits after each edge
`timescale 1ns/1ps
`default_nettype none
module tb_timer_counter_modes
    import timer_counter_pkg::*;
;
    logic        clock;
    logic        arst_n;
    logic        counterClock;
    logic        gateIn;
    logic        controlWrite;
    logic [2:0]  modeSelect;
    logic        bcdSelect;
    logic        countWrite;
    logic [15:0] countData;
    logic        timerOut;
    logic [15:0] countValue;
    int          nMismatch;
    int          samplesChecked;
    int          cycles;

    timer_counter_modes u_dut (
        .clock        (clock),
        .arst_n       (arst_n),
        .counterClock (counterClock),
        .gateIn       (gateIn),
        .controlWrite (controlWrite),
        .modeSelect   (modeSelect),
        .bcdSelect    (bcdSelect),
        .countWrite   (countWrite),
        .countData    (countData),
        .timerOut     (timerOut),
        .countValue   (countValue)
    );

    host_model u_host (
        .clock        (clock),
        .controlWrite (controlWrite),
        .modeSelect   (modeSelect),
        .bcdSelect    (bcdSelect),
        .countWrite   (countWrite),
        .countData    (countData)
    );

    initial
    begin
        clock          = 1'b0;
        arst_n         = 1'b0;
        counterClock   = 1'b0;
        gateIn         = 1'b1;
        nMismatch      = 0;
        samplesChecked = 0;
        cycles         = 0;
    end

    always #50 clock = ~clock;

    // hang guard: whole run needs well under 3000 cycles
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            nMismatch++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checked %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic checkBit(input logic got, input logic exp);
        samplesChecked++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // one counter clock pulse, then room for filter and output lag
    task automatic pulse();
        counterClock <= 1'b1;
        tick(5);
        counterClock <= 1'b0;
        tick(6);
    endtask

    // filter takes four clocks, the registered output one more
    task automatic setGate(input logic level);
        gateIn <= level;
        tick(6);
    endtask

    // bit i of exp is the output level after pulse i
    task automatic runOuts(input int n, input logic [15:0] exp);
        for (int i = 0; i < n; i++)
        begin
            pulse();
            checkBit(timerOut, exp[i]);
        end
    endtask

    task automatic start(input logic [2:0] mode, input logic bcd,
                         input logic [15:0] n);
        u_host.writeControl(mode, bcd);
        tick(2);
        checkBit(timerOut, 1'b1);
        u_host.writeCount(n);
        tick(2);
    endtask

    task automatic testRate();
        start(MODE_RATE, 1'b0, 16'h0003);
        runOuts(6, 16'h001B);
        setGate(1'b0);
        checkBit(timerOut, 1'b1);
        pulse();
        checkWord(countValue, 16'h0001);
        setGate(1'b1);
        pulse();
        checkWord(countValue, 16'h0003);
        u_host.writeCount(16'h0004);
        runOuts(2, 16'h0001);
        pulse();
        checkWord(countValue, 16'h0004);
    endtask

    task automatic testSquare();
        start(MODE_SQUARE, 1'b0, 16'h0005);
        runOuts(6, 16'h0027);
        runOuts(4, 16'h0003);
        setGate(1'b0);
        checkBit(timerOut, 1'b1);
        setGate(1'b1);
        start(MODE_SQUARE, 1'b0, 16'h0004);
        runOuts(6, 16'h0033);
        runOuts(5, 16'h000C);
        u_host.writeControl(MODE_SQUARE, 1'b0);
        tick(2);
        checkBit(timerOut, 1'b1);
    endtask

    task automatic testSoft();
        start(MODE_SW_STROBE, 1'b0, 16'h0003);
        runOuts(5, 16'h0017);
        checkWord(countValue, WRAP_BINARY);
        setGate(1'b0);
        pulse();
        checkWord(countValue, WRAP_BINARY);
        checkBit(timerOut, 1'b1);
        setGate(1'b1);
        u_host.writeCount(16'h0002);
        pulse();
        checkWord(countValue, 16'h0002);
        u_host.writeCount(COUNT_RESET);
        pulse();
        pulse();
        checkWord(countValue, WRAP_BINARY);
        start(MODE_SW_STROBE, 1'b1, 16'h0010);
        pulse();
        pulse();
        checkWord(countValue, 16'h0009);
        u_host.writeCount(COUNT_RESET);
        pulse();
        pulse();
        checkWord(countValue, WRAP_DECIMAL);
    endtask

    task automatic testHard();
        start(MODE_HW_STROBE, 1'b0, 16'h0002);
        runOuts(2, 16'h0003);
        setGate(1'b0);
        setGate(1'b1);
        pulse();
        checkWord(countValue, 16'h0002);
        runOuts(3, 16'h0005);
        u_host.writeCount(16'h0003);
        pulse();
        checkWord(countValue, 16'hFFFE);
        setGate(1'b0);
        setGate(1'b1);
        pulse();
        checkWord(countValue, 16'h0003);
    endtask

    initial
    begin
        tick(3);
        arst_n <= 1'b1;
        tick(3);
        testRate();
        testSquare();
        testSoft();
        testHard();
        final_report();
    end
endmodule // tb_timer_counter_modes
`default_nettype wire
